// >>> rtl/osp_port.sv
// DS3/E3 receive overhead output port and transmit serial input port
`timescale 1ns/1ps

module osp_tx_link
	import osp_pkg::*;
(
	// Link clock and reset
	input wire logic tx_clk,
	input wire logic rst_b,
	// Configuration, quasi-static, from the system domain
	input wire osp_fmt_e fmt,
	input wire osp_ref_e ref_sel,
	input wire logic [REF_NUM-1:0] ref_inv,
	input wire logic inv_tx_frame_align,
	input wire logic inv_tx_serial,
	input wire logic inv_tx_clock_output,
	input wire logic tx_clock_select_field,
	input wire logic loop_timed,
	input wire logic adapter_clock_source_field,
	// Pins
	input wire logic tx_clock_input,
	input wire logic tx_line_clock,
	input wire logic rx_clock_output,
	input wire logic rx_line_clock,
	input wire logic tx_frame_align_input,
	input wire logic tx_serial_data,
	output logic tx_clock_output,
	output logic tx_data_enable,
	// Framer side
	input wire logic frm_payload_lead,
	output logic tx_payload_valid,
	output logic tx_payload_data,
	output logic tx_frame_align,
	output logic tx_align_toggle
);
	typedef struct packed {
		logic [TX_CFG_W-1:0] cfg1;
		logic [TX_CFG_W-1:0] cfg2;
		logic [3:0] ref1;
		logic [3:0] ref2;
		logic [1:0] dat1;
		logic [1:0] dat2;
		logic ref_prev;
		logic tfa_last;
		logic enable;
		logic [TX_LEAD_CLKS-1:0] pipe;
		logic pvalid;
		logic pdata;
		logic align;
		logic tgl;
	} osp_tx_state_s;

	osp_tx_state_s q;
	osp_tx_state_s d;
	osp_fmt_e c_fmt;
	osp_ref_e c_sel;
	osp_ref_e sel_eff;
	logic [REF_NUM-1:0] c_inv;
	logic c_clear;
	logic c_gapped;
	logic ref_lvl;
	logic ref_now;
	logic tfa;
	logic gate;
	logic clk_en;

	// Decode of the synchronised configuration
	assign c_fmt = osp_fmt_e'(q.cfg2[16:14]);
	assign c_sel = osp_ref_e'(q.cfg2[13:11]);
	assign c_inv = q.cfg2[10:6];
	assign c_clear = (c_fmt == FMT_CLEAR);
	assign c_gapped = q.cfg2[2];
	assign gate = q.pipe[TX_LEAD_CLKS-1];

	// Clock input is meaningless without its own timing source
	assign sel_eff = (c_sel == REF_TX_CLK_IN && (q.cfg2[1] || q.cfg2[0])) ? REF_TX_CLK_OUT : c_sel;

	// Selected reference level, already synchronised
	always_comb
	begin
		unique case (sel_eff)
			REF_TX_CLK_IN: ref_lvl = q.ref2[0];
			REF_TX_LINE_CLK: ref_lvl = q.ref2[1];
			REF_RX_CLK_OUT: ref_lvl = q.ref2[2];
			REF_RX_LINE_CLK: ref_lvl = q.ref2[3];
			default: ref_lvl = 1'b0;
		endcase
	end

	// Inverted reference turns the falling edge into the sampling edge
	assign ref_now = (sel_eff == REF_TX_CLK_OUT) ? 1'b1 :
		((ref_lvl ^ c_inv[sel_eff]) && !q.ref_prev);
	assign tfa = q.dat2[1] ^ q.cfg2[5];

	// Next state of the link side
	always_comb
	begin
		d = q;
		d.cfg1 = {fmt, ref_sel, ref_inv, inv_tx_frame_align, inv_tx_serial, inv_tx_clock_output,
			tx_clock_select_field, loop_timed, adapter_clock_source_field};
		d.cfg2 = q.cfg1;
		d.ref1 = {rx_line_clock, rx_clock_output, tx_line_clock, tx_clock_input};
		d.ref2 = q.ref1;
		d.dat1 = {tx_frame_align_input, tx_serial_data};
		d.dat2 = q.dat1;
		d.ref_prev = ref_lvl ^ c_inv[sel_eff];
		d.align = 1'b0;
		d.pvalid = 1'b0;
		if (ref_now)
		begin
			d.tfa_last = tfa;
			d.align = tfa && !q.tfa_last;
			d.pdata = q.dat2[0] ^ q.cfg2[4];
			d.pvalid = c_clear || gate;
		end
		// A static alignment input gives no pulse; the framer keeps its own count
		if (d.align)
			d.tgl = ~q.tgl;
		d.enable = !c_clear && frm_payload_lead;
		d.pipe = {q.pipe[TX_LEAD_CLKS-2:0], q.enable};
	end

	// Link state register
	always_ff @(posedge tx_clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= d;
	end

	// Gate moves just after a rising edge, so a stop can leave a short runt
	assign clk_en = !c_gapped || c_clear || gate;
	assign tx_clock_output = (tx_clk & clk_en) ^ q.cfg2[3];
	assign tx_data_enable = q.enable;
	assign tx_payload_valid = q.pvalid;
	assign tx_payload_data = q.pdata;
	assign tx_frame_align = q.align;
	assign tx_align_toggle = q.tgl;

	localparam int LEAD = 3;

	property p_tx_ignore_clk_in;
		@(posedge tx_clk) disable iff (!rst_b)
		(c_sel == REF_TX_CLK_IN && (q.cfg2[1] || q.cfg2[0])) |-> ref_now;
	endproperty
	a_tx_ignore_clk_in: assert property (p_tx_ignore_clk_in) else $error("clock input used");

	property p_tx_align_edge;
		@(posedge tx_clk) disable iff (!rst_b)
		(ref_now && tfa && !q.tfa_last) |=> tx_frame_align;
	endproperty
	a_tx_align_edge: assert property (p_tx_align_edge) else $error("alignment edge missed");

	property p_tx_no_spurious_align;
		@(posedge tx_clk) disable iff (!rst_b)
		!(ref_now && tfa && !q.tfa_last) |=> !tx_frame_align;
	endproperty
	a_tx_no_spurious_align: assert property (p_tx_no_spurious_align) else $error("spurious alignment");

	property p_tx_sample_edge;
		@(posedge tx_clk) disable iff (!rst_b)
		(sel_eff != REF_TX_CLK_OUT && ref_now) |-> ((ref_lvl ^ c_inv[sel_eff]) && !q.ref_prev);
	endproperty
	a_tx_sample_edge: assert property (p_tx_sample_edge) else $error("sample off edge");

	property p_tx_payload_only;
		@(posedge tx_clk) disable iff (!rst_b)
		tx_payload_valid |-> $past(c_clear) || $past(gate);
	endproperty
	a_tx_payload_only: assert property (p_tx_payload_only) else $error("overhead bit taken");

	property p_tx_enable_lead;
		@(posedge tx_clk) disable iff (!rst_b)
		$changed(tx_data_enable) |-> ##LEAD (gate == $past(tx_data_enable, 3));
	endproperty
	a_tx_enable_lead: assert property (p_tx_enable_lead) else $error("enable lead wrong");

	property p_tx_gapped;
		@(posedge tx_clk) disable iff (!rst_b)
		(c_gapped && !c_clear) |-> (clk_en == gate);
	endproperty
	a_tx_gapped: assert property (p_tx_gapped) else $error("gapped clock gate wrong");

	property p_tx_continuous;
		@(posedge tx_clk) disable iff (!rst_b)
		!c_gapped |-> clk_en;
	endproperty
	a_tx_continuous: assert property (p_tx_continuous) else $error("continuous clock gated");

	c_tx_align: cover property (@(posedge tx_clk) disable iff (!rst_b) tx_frame_align);
	c_tx_payload: cover property (@(posedge tx_clk) disable iff (!rst_b) tx_payload_valid && c_gapped);
endmodule : osp_tx_link

module osp_port
	import osp_pkg::*;
(
	// System clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Mode and polarity
	input wire osp_fmt_e fmt,
	input wire logic inv_rx_oh_data,
	input wire logic inv_rx_oh_clock,
	input wire logic inv_rx_oh_start,
	// Framer overhead bits
	input wire logic rx_oh_valid,
	input wire logic rx_oh_bit,
	input wire osp_cls_e rx_oh_class,
	output logic rx_oh_ready,
	// Receive overhead pins
	output logic rx_overhead_data,
	output logic rx_overhead_clock,
	output logic rx_overhead_seq_start,
	// Transmit configuration
	input wire osp_ref_e ref_sel,
	input wire logic [REF_NUM-1:0] ref_inv,
	input wire logic inv_tx_frame_align,
	input wire logic inv_tx_serial,
	input wire logic inv_tx_clock_output,
	input wire logic tx_clock_select_field,
	input wire logic loop_timed,
	input wire logic adapter_clock_source_field,
	output logic tx_align_event,
	// Transmit link
	input wire logic tx_clk,
	input wire logic tx_clock_input,
	input wire logic tx_line_clock,
	input wire logic rx_clock_output,
	input wire logic rx_line_clock,
	input wire logic tx_frame_align_input,
	input wire logic tx_serial_data,
	output logic tx_clock_output,
	output logic tx_data_enable,
	input wire logic frm_payload_lead,
	output logic tx_payload_valid,
	output logic tx_payload_data,
	output logic tx_frame_align
);
	typedef struct packed {
		osp_rx_st_e st;
		logic [RX_OH_CNT_W-1:0] cnt;
		logic hold_v;
		logic hold_bit;
		logic hold_first;
		logic oh_bit;
		logic oh_first;
		logic clk_lvl;
		logic pin_clk;
		logic pin_dat;
		logic pin_sof;
		logic aln1;
		logic aln2;
		logic aln3;
		logic evt;
	} osp_rx_state_s;

	osp_rx_state_s q;
	osp_rx_state_s d;
	logic tgl;
	logic clear;
	logic fwd;
	logic take;
	logic load;

	osp_tx_link u_tx (
		.tx_clk(tx_clk),
		.rst_b(rst_b),
		.fmt(fmt),
		.ref_sel(ref_sel),
		.ref_inv(ref_inv),
		.inv_tx_frame_align(inv_tx_frame_align),
		.inv_tx_serial(inv_tx_serial),
		.inv_tx_clock_output(inv_tx_clock_output),
		.tx_clock_select_field(tx_clock_select_field),
		.loop_timed(loop_timed),
		.adapter_clock_source_field(adapter_clock_source_field),
		.tx_clock_input(tx_clock_input),
		.tx_line_clock(tx_line_clock),
		.rx_clock_output(rx_clock_output),
		.rx_line_clock(rx_line_clock),
		.tx_frame_align_input(tx_frame_align_input),
		.tx_serial_data(tx_serial_data),
		.tx_clock_output(tx_clock_output),
		.tx_data_enable(tx_data_enable),
		.frm_payload_lead(frm_payload_lead),
		.tx_payload_valid(tx_payload_valid),
		.tx_payload_data(tx_payload_data),
		.tx_frame_align(tx_frame_align),
		.tx_align_toggle(tgl)
	);

	// Which framer bits belong on the overhead output
	assign clear = (fmt == FMT_CLEAR);
	assign fwd = !clear && (rx_oh_class == CLS_OVH || rx_oh_class == CLS_OVH_FIRST ||
		(rx_oh_class == CLS_CBIT && (fmt == FMT_T3_CBIT || fmt == FMT_T3_M23)));
	assign rx_oh_ready = !q.hold_v;
	assign take = rx_oh_valid && rx_oh_ready;

	// Overhead serialiser; bits leave only at a falling overhead clock edge
	always_comb
	begin
		d = q;
		load = 1'b0;
		d.aln1 = tgl;
		d.aln2 = q.aln1;
		d.aln3 = q.aln2;
		d.evt = q.aln2 ^ q.aln3;
		unique case (q.st)
			RX_IDLE: load = q.hold_v;
			RX_LOW:
			begin
				d.cnt = RX_OH_CNT_W'(q.cnt + 8'h01);
				if (q.cnt == RX_OH_HALF_M1)
				begin
					d.st = RX_HIGH;
					d.cnt = RX_OH_CNT_RST;
					d.clk_lvl = 1'b1;
				end
			end
			RX_HIGH:
			begin
				d.cnt = RX_OH_CNT_W'(q.cnt + 8'h01);
				if (q.cnt == RX_OH_HALF_M1)
				begin
					load = q.hold_v;
					d.cnt = RX_OH_CNT_RST;
					d.st = RX_IDLE;
				end
			end
			default: d.st = RX_IDLE;
		endcase
		if (load)
		begin
			d.st = RX_LOW;
			d.clk_lvl = 1'b0;
			d.oh_bit = q.hold_bit;
			d.oh_first = q.hold_first;
			d.hold_v = 1'b0;
		end
		if (take && fwd)
		begin
			d.hold_v = 1'b1;
			d.hold_bit = rx_oh_bit;
			d.hold_first = (rx_oh_class == CLS_OVH_FIRST);
		end
		if (clear)
		begin
			d.st = RX_IDLE;
			d.cnt = RX_OH_CNT_RST;
			d.hold_v = 1'b0;
			d.clk_lvl = RX_CLK_IDLE;
			d.oh_bit = RX_PIN_RST;
			d.oh_first = RX_PIN_RST;
		end
		d.pin_clk = d.clk_lvl ^ inv_rx_oh_clock;
		d.pin_dat = d.oh_bit ^ inv_rx_oh_data;
		d.pin_sof = d.oh_first ^ inv_rx_oh_start;
	end

	// System state register
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.clk_lvl <= RX_CLK_IDLE;
			q.pin_clk <= RX_CLK_IDLE;
		end
		else
			q <= d;
	end

	assign rx_overhead_data = q.pin_dat;
	assign rx_overhead_clock = q.pin_clk;
	assign rx_overhead_seq_start = q.pin_sof;
	assign tx_align_event = q.evt;

	localparam int MARK_WAIT = 2 * RX_OH_HALF_CYC + 2;

	property p_rx_change_on_fall;
		@(posedge mclk) disable iff (!rst_b)
		(!clear && $past(fmt) != FMT_CLEAR && $changed(q.oh_bit)) |-> $fell(q.clk_lvl);
	endproperty
	a_rx_change_on_fall: assert property (p_rx_change_on_fall) else $error("data moved off fall");

	property p_rx_marker_fall;
		@(posedge mclk) disable iff (!rst_b)
		$rose(q.oh_first) |-> $fell(q.clk_lvl);
	endproperty
	a_rx_marker_fall: assert property (p_rx_marker_fall) else $error("marker off fall");

	property p_rx_first_marked;
		@(posedge mclk) disable iff (!rst_b)
		(take && fwd && rx_oh_class == CLS_OVH_FIRST) |-> ##[1:MARK_WAIT] (q.oh_first || clear);
	endproperty
	a_rx_first_marked: assert property (p_rx_first_marked) else $error("first bit not marked");

	property p_rx_m23_cbits;
		@(posedge mclk) disable iff (!rst_b)
		(take && rx_oh_class == CLS_CBIT && fmt == FMT_T3_M23) |=> q.hold_v;
	endproperty
	a_rx_m23_cbits: assert property (p_rx_m23_cbits) else $error("M23 C bit dropped");

	property p_rx_e3_overhead;
		@(posedge mclk) disable iff (!rst_b)
		(take && rx_oh_class == CLS_OVH && (fmt == FMT_E3_G751 || fmt == FMT_E3_G832)) |=> q.hold_v;
	endproperty
	a_rx_e3_overhead: assert property (p_rx_e3_overhead) else $error("E3 overhead dropped");

	property p_rx_clear_idle;
		@(posedge mclk) disable iff (!rst_b)
		(clear && $past(clear) && $stable(inv_rx_oh_data) && $stable(inv_rx_oh_start) &&
			$stable(inv_rx_oh_clock)) |-> (rx_overhead_data == inv_rx_oh_data &&
			rx_overhead_seq_start == inv_rx_oh_start && rx_overhead_clock == !inv_rx_oh_clock);
	endproperty
	a_rx_clear_idle: assert property (p_rx_clear_idle) else $error("overhead active in clear mode");

	property p_rx_clock_polarity;
		@(posedge mclk) disable iff (!rst_b)
		##1 (rx_overhead_clock == (q.clk_lvl ^ $past(inv_rx_oh_clock)));
	endproperty
	a_rx_clock_polarity: assert property (p_rx_clock_polarity) else $error("clock polarity wrong");

	c_rx_sequence: cover property (@(posedge mclk) disable iff (!rst_b) $rose(q.oh_first));
	c_rx_back_to_back: cover property (@(posedge mclk) disable iff (!rst_b) $fell(q.clk_lvl) && take && fwd);
endmodule : osp_port

// >>> rtl/osp_pkg.sv
// Constants and types of the DS3/E3 overhead output and serial data input port
package osp_pkg;
	typedef enum logic [2:0] {FMT_T3_CBIT, FMT_T3_M23, FMT_E3_G751, FMT_E3_G832, FMT_CLEAR} osp_fmt_e;
	typedef enum logic [1:0] {CLS_PAYLOAD, CLS_CBIT, CLS_OVH, CLS_OVH_FIRST} osp_cls_e;
	typedef enum logic [2:0] {REF_TX_CLK_IN, REF_TX_LINE_CLK, REF_TX_CLK_OUT, REF_RX_CLK_OUT,
		REF_RX_LINE_CLK} osp_ref_e;
	typedef enum logic [1:0] {RX_IDLE, RX_LOW, RX_HIGH} osp_rx_st_e;

	// System clock and overhead clock timing
	localparam int MCLK_PERIOD_NS = 50;
	localparam int RX_OH_HALF_NS = 200;
	localparam int RX_OH_HALF_CYC = (RX_OH_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int RX_OH_CNT_W = 8;
	localparam logic [RX_OH_CNT_W-1:0] RX_OH_HALF_M1 = RX_OH_CNT_W'(RX_OH_HALF_CYC - 1);
	localparam logic [RX_OH_CNT_W-1:0] RX_OH_CNT_RST = 8'h00;

	// Transmit side
	localparam int TX_LEAD_CLKS = 3;
	localparam int REF_NUM = 5;
	localparam int TX_CFG_W = 17;

	// Values after reset
	localparam logic RX_PIN_RST = 1'b0;
	localparam logic RX_CLK_IDLE = 1'b1;
endpackage : osp_pkg

// >>> testbench/osp_far_end.sv
// Far-end logic model for the overhead and serial ports
`timescale 1ns/1ps

module osp_far_end
(
	// Overhead pins and far-end polarity
	input wire logic rx_overhead_clock,
	input wire logic rx_overhead_data,
	input wire logic rx_overhead_seq_start,
	input wire logic [2:0] oh_inv,
	// Transmit stimulus control
	input wire logic ref_run,
	input wire logic ref_fall,
	input wire logic ser_val,
	input wire logic align_lvl,
	// Captured overhead
	output logic [7:0] cap_cnt = 8'h00,
	output logic [7:0] cap_bits = 8'h00,
	output logic [7:0] cap_starts = 8'h00,
	// Transmit pins
	output logic ref_clk = 1'b0,
	output logic tx_serial_data = 1'b0,
	output logic tx_frame_align_input = 1'b0
);
	logic oh_clk;

	// Polarity undone so capture keys on the logical rise
	assign oh_clk = rx_overhead_clock ^ oh_inv[1];

	// Shift in data and marker on the rise
	always @(posedge oh_clk)
	begin
		cap_cnt <= cap_cnt + 8'h01;
		cap_bits <= {cap_bits[6:0], rx_overhead_data ^ oh_inv[0]};
		cap_starts <= {cap_starts[6:0], rx_overhead_seq_start ^ oh_inv[2]};
	end

	// Data moves away from the edge the host samples
	task drive(input logic en);
		if (en)
		begin
			tx_serial_data = ser_val;
			tx_frame_align_input = align_lvl;
		end
	endtask : drive

	// Whole periods only; the clock rests low between runs
	initial
	begin
		forever
		begin
			wait (ref_run === 1'b1);
			#60;
			drive(!ref_fall);
			#60;
			ref_clk = 1'b1;
			#60;
			drive(ref_fall);
			#60;
			ref_clk = 1'b0;
		end
	end
endmodule : osp_far_end

// >>> testbench/osp_port_tb_top.sv
// Self-checking bench for the overhead output and serial input port
`timescale 1ns/1ps

module osp_port_tb_top
	import osp_pkg::*;
;
	// Clocks, reset and configuration
	logic mclk = 1'b0;
	logic tx_clk = 1'b0;
	logic rst_b = 1'b0;
	osp_fmt_e fmt = FMT_T3_CBIT;
	osp_ref_e ref_sel = REF_TX_CLK_IN;
	logic [REF_NUM-1:0] ref_inv = 5'h00;
	logic [2:0] oh_inv = 3'h0;
	logic inv_tx_frame_align = 1'b0;
	logic inv_tx_serial = 1'b0;
	logic inv_tx_clock_output = 1'b0;
	logic tx_clock_select_field = 1'b0;
	logic loop_timed = 1'b0;
	logic adapter_clock_source_field = 1'b0;
	// Framer side
	logic rx_oh_valid = 1'b0;
	logic rx_oh_bit = 1'b0;
	osp_cls_e rx_oh_class = CLS_OVH;
	logic frm_payload_lead = 1'b0;
	logic rx_oh_ready, tx_align_event, tx_payload_valid, tx_payload_data, tx_frame_align;
	// Pins and far-end control
	logic rx_overhead_data, rx_overhead_clock, rx_overhead_seq_start;
	logic tx_clock_input, tx_line_clock, rx_clock_output, rx_line_clock;
	logic tx_frame_align_input, tx_serial_data, tx_clock_output, tx_data_enable;
	logic ref_run = 1'b0;
	logic ser_val = 1'b0;
	logic align_lvl = 1'b0;
	logic ref_clk;
	logic [3:0] route = 4'h1;
	logic [7:0] cap_cnt, cap_bits, cap_starts;
	int err_count = 0;
	int checks_done = 0;
	int vcnt = 0;
	int acnt = 0;
	int ecnt = 0;
	int v, a, e0;
	osp_ref_e refs[4] = '{REF_TX_CLK_IN, REF_TX_LINE_CLK, REF_RX_CLK_OUT, REF_RX_LINE_CLK};

	// Reference reaches only the routed clock pin
	assign {rx_line_clock, rx_clock_output, tx_line_clock, tx_clock_input} = route & {4{ref_clk}};

	osp_port u_dut (.mclk, .rst_b, .fmt, .inv_rx_oh_data(oh_inv[0]), .inv_rx_oh_clock(oh_inv[1]),
		.inv_rx_oh_start(oh_inv[2]), .rx_oh_valid, .rx_oh_bit, .rx_oh_class, .rx_oh_ready,
		.rx_overhead_data, .rx_overhead_clock, .rx_overhead_seq_start, .ref_sel, .ref_inv,
		.inv_tx_frame_align, .inv_tx_serial, .inv_tx_clock_output, .tx_clock_select_field, .loop_timed,
		.adapter_clock_source_field, .tx_align_event, .tx_clk, .tx_clock_input, .tx_line_clock,
		.rx_clock_output, .rx_line_clock, .tx_frame_align_input, .tx_serial_data, .tx_clock_output,
		.tx_data_enable, .frm_payload_lead, .tx_payload_valid, .tx_payload_data, .tx_frame_align);

	osp_far_end u_far (.rx_overhead_clock, .rx_overhead_data, .rx_overhead_seq_start, .oh_inv, .ref_run,
		.ref_fall(ref_inv[0]), .ser_val, .align_lvl, .cap_cnt, .cap_bits, .cap_starts, .ref_clk,
		.tx_serial_data, .tx_frame_align_input);

	// System clock, and a link clock of unrelated phase
	initial
	begin
		forever
			#25 mclk = ~mclk;
	end
	initial
	begin
		#7;
		forever
			#15 tx_clk = ~tx_clk;
	end

	// Pulse counters; tests compare deltas, never reset them
	always @(posedge tx_clk)
	begin
		vcnt <= vcnt + int'(tx_payload_valid === 1'b1);
		acnt <= acnt + int'(tx_frame_align === 1'b1);
	end
	always @(posedge mclk)
		ecnt <= ecnt + int'(tx_align_event === 1'b1);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task give_verdict;
		$display("Checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic mw(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : mw

	task automatic tw(input int n);
		repeat (n) @(posedge tx_clk);
		#2;
	endtask : tw

	// Offer one bit; valid is held by the caller across the burst
	task automatic send(input osp_cls_e c, input logic b);
		int n;
		n = 0;
		rx_oh_class = c;
		rx_oh_bit = b;
		while (rx_oh_ready !== 1'b1 && n < 100)
		begin
			mw(1);
			n++;
		end
		mw(1);
	endtask : send

	// First mark, payload, C bit, then two plain overhead bits
	task automatic oh_seq(input osp_fmt_e f, input logic [7:0] n, input logic [7:0] bits, input logic [7:0] st);
		logic [7:0] c0;
		logic [7:0] m;
		fmt = f;
		mw(12);
		c0 = cap_cnt;
		rx_oh_valid = 1'b1;
		send(CLS_OVH_FIRST, 1'b1);
		check("ready after first bit", rx_oh_ready, f == FMT_CLEAR);
		send(CLS_PAYLOAD, 1'b0);
		send(CLS_CBIT, 1'b0);
		send(CLS_OVH, 1'b1);
		send(CLS_OVH, 1'b0);
		rx_oh_valid = 1'b0;
		mw(30);
		m = (8'h01 << n) - 8'h01;
		check("overhead count", cap_cnt - c0, n);
		check("overhead bits", cap_bits & m, bits);
		check("overhead marker", cap_starts & m, st);
	endtask : oh_seq

	// Whole reference periods, then time for the crossing to settle
	task automatic tx_run(input int n);
		int v0, a0;
		v0 = vcnt;
		a0 = acnt;
		ref_run = 1'b1;
		#(240 * n - 30);
		ref_run = 1'b0;
		tw(20);
		v = vcnt - v0;
		a = acnt - a0;
	endtask : tx_run

	task automatic cyc;
		tw(6);
		v = vcnt;
		tw(20);
		check("every clock samples", vcnt - v, 20);
	endtask : cyc

	// Enable follows the lead; the gated clock trails it by three clocks
	task automatic lead_step(input logic lv);
		frm_payload_lead = lv;
		tw(1);
		check("data enable", tx_data_enable, lv);
		check("gapped clock early", tx_clock_output, !lv);
		tw(2);
		check("gapped clock third", tx_clock_output, !lv);
		tw(1);
		check("gapped clock", tx_clock_output, lv);
	endtask : lead_step

	// Watchdog at about four times the expected run length
	initial
	begin
		#200000;
		err_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		give_verdict();
	end

	initial
	begin
		mw(6);
		rst_b = 1'b1;
		oh_seq(FMT_T3_CBIT, 8'h04, 8'h0a, 8'h08);
		oh_seq(FMT_T3_M23, 8'h04, 8'h0a, 8'h08);
		oh_seq(FMT_E3_G751, 8'h03, 8'h06, 8'h04);
		oh_seq(FMT_E3_G832, 8'h03, 8'h06, 8'h04);
		oh_seq(FMT_CLEAR, 8'h00, 8'h00, 8'h00);
		check("clear clock level", rx_overhead_clock, 1'b1);
		check("clear data level", rx_overhead_data, 1'b0);
		oh_inv = 3'h7;
		oh_seq(FMT_T3_CBIT, 8'h04, 8'h0a, 8'h08);
		check("inverted idle clock", rx_overhead_clock, 1'b0);
		oh_inv = 3'h0;
		// Clear channel: every reference rise delivers a bit
		fmt = FMT_CLEAR;
		ser_val = 1'b1;
		tw(6);
		tx_run(6);
		check("clear samples", v, 6);
		check("serial bit", tx_payload_data, 1'b1);
		ref_inv = 5'h01;
		inv_tx_serial = 1'b1;
		tw(6);
		tx_run(4);
		check("falling samples", v, 4);
		check("inverted serial", tx_payload_data, 1'b0);
		ref_inv = 5'h00;
		inv_tx_serial = 1'b0;
		// Each reference pin, first with another pin toggling
		for (int i = 0; i < 4; i++)
		begin
			ref_sel = refs[i];
			route = 4'(1 << ((i + 1) % 4));
			tw(6);
			tx_run(3);
			check("unselected reference", v, 0);
			route = 4'(1 << i);
			tw(6);
			tx_run(3);
			check("selected reference", v, 3);
		end
		// Reference back on the clock input pin for the framed runs
		route = 4'h1;
		// Clock input ignored: sampling on every framer clock
		ref_sel = REF_TX_CLK_IN;
		loop_timed = 1'b1;
		cyc();
		loop_timed = 1'b0;
		adapter_clock_source_field = 1'b1;
		cyc();
		adapter_clock_source_field = 1'b0;
		ref_sel = REF_TX_CLK_OUT;
		cyc();
		ref_sel = REF_TX_CLK_IN;
		// Framed mode takes nothing outside payload
		fmt = FMT_T3_CBIT;
		tw(6);
		tx_run(3);
		check("framed gap samples", v, 0);
		tx_clock_select_field = 1'b1;
		tw(6);
		lead_step(1'b1);
		tx_run(3);
		check("payload samples", v, 3);
		lead_step(1'b0);
		tx_clock_select_field = 1'b0;
		tw(6);
		check("continuous high", tx_clock_output, 1'b1);
		#15;
		check("continuous low", tx_clock_output, 1'b0);
		tw(1);
		inv_tx_clock_output = 1'b1;
		tw(6);
		check("inverted clock", tx_clock_output, 1'b0);
		inv_tx_clock_output = 1'b0;
		// One pulse per alignment rise, none while static
		e0 = ecnt;
		align_lvl = 1'b1;
		tx_run(3);
		check("alignment rise", a, 1);
		tx_run(3);
		check("static alignment", a, 0);
		// Inverted high input reads low first, so the later fall is the logical rise
		inv_tx_frame_align = 1'b1;
		tw(6);
		tx_run(3);
		check("inverted high level", a, 0);
		align_lvl = 1'b0;
		tx_run(3);
		check("inverted alignment", a, 1);
		mw(6);
		check("alignment events", ecnt - e0, 2);
		give_verdict();
	end
endmodule : osp_port_tb_top
